// >>> hw/nfh_defs.svh
// Purpose: constants of the NAND erase/reset/feature host sequencer
// Assumes: 100 MHz clock, one byte-wide NAND target
// Notes: offsets are byte addresses on the software port
`ifndef NFH_DEFS_SVH
`define NFH_DEFS_SVH

// ----------------------------------------------------------------
// Software register map
// ----------------------------------------------------------------
`define NFH_REG_CTRL 8'h00
`define NFH_REG_ADDR 8'h04
`define NFH_REG_DATA 8'h08
`define NFH_REG_STAT 8'h0C
`define NFH_REG_WP 8'h10
`define NFH_WP_RESET 1'h1

// ----------------------------------------------------------------
// Device command bytes and feature addresses
// ----------------------------------------------------------------
`define NFH_CMD_ERASE_SETUP 8'h60
`define NFH_CMD_ERASE_CONF 8'hD0
`define NFH_CMD_QUEUE_CONF 8'hD1
`define NFH_CMD_STATUS 8'h70
`define NFH_CMD_STATUS_PLANE 8'h78
`define NFH_CMD_RESET 8'hFF
`define NFH_CMD_GET_FEAT 8'hEE
`define NFH_CMD_SET_FEAT 8'hEF
`define NFH_FEAT_DRIVE 8'h80
`define NFH_FEAT_PULLDOWN 8'h81
`define NFH_STRENGTH_MASK 8'h03

// ----------------------------------------------------------------
// Status byte fields and row layout
// ----------------------------------------------------------------
`define NFH_SR_READY 6
`define NFH_SR_ARRAY_READY 5
`define NFH_SR_FAIL 0
`define NFH_SR_RST_WP_HI 8'hE0
`define NFH_SR_RST_WP_LO 8'h60
`define NFH_PAGE_BITS 6
`define NFH_PAGES_PER_BLOCK 64
`define NFH_BLOCKS 2048
`define NFH_PLANE_BIT 6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define NFH_CLK_NS 10
`define NFH_T_STROBE_LOW_NS 40
`define NFH_T_WB_NS 100
`define NFH_STROBE_LOW_CYC ((`NFH_T_STROBE_LOW_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_STROBE_CYC (2 * `NFH_STROBE_LOW_CYC)
`define NFH_WB_CYC (`NFH_T_WB_NS / `NFH_CLK_NS)

`endif

// >>> hw/nfh_host.sv
// Purpose: host sequencer for NAND erase, reset, status and features
// Assumes: software port with one-cycle strobes, read data a cycle later
// Notes: pins come straight from flip-flops
//
// What this block does
// - Erase is 60h, three row cycles, D0h; page bits sent as zero.
// - Plane queue is 60h, three rows, D1h; device then briefly busy.
// - Further queue only after status bits six and five both one.
// - Progress watched on ready/busy; 70h and 78h both answered.
// - The two queued addresses differ in the plane select bit.
// - Both planes use the same operation type, never mixed.
// - Feature write latches four bytes then goes busy.
// - Feature read goes busy, then bytes clocked out by read strobe.
//
// Design decision made here: the address-and-strobe port.
`include "nfh_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module nfh_host (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output var logic [31:0] rdata_out,
   input wire logic [7:0] io_in,
   input wire logic ready_busy_n_in,
   output var nfh_pkg::nfh_pins_t pins_out,
   output var logic wp_n_out
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   nfh_pkg::nfh_state_t st_q, st_d;
   nfh_pkg::nfh_op_t op_q, op_d;
   nfh_pkg::nfh_pins_t pins_d;
   logic [2:0] ph_q, ph_d;
   logic [1:0] idx_q, idx_d;
   logic [3:0] wcnt_q, wcnt_d;
   logic seen_low_q, seen_low_d;
   logic [23:0] row_q, row_d;
   logic [31:0] data_q, data_d, rdata_d;
   logic [7:0] sr_q, sr_d;
   logic queued_q, queued_d, qplane_q, qplane_d;
   logic refused_q, refused_d, rst_bad_q, rst_bad_d, wp_d;
   logic [8:0] sync_w;
   logic [7:0] io_s;
   logic rb_s, strobe_end, ctrl_wr, op_ok, busy;
   nfh_pkg::nfh_op_t wop;

   nfh_sync #(.WIDTH(9)) u_sync (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .d_in({ready_busy_n_in, io_in}),
      .q_out(sync_w)
   );
   assign io_s = sync_w[7:0];
   assign rb_s = sync_w[8];

   // Index of the last address cycle per operation
   function automatic logic [1:0] addr_last(input nfh_pkg::nfh_op_t op);
      unique case (op)
         nfh_pkg::OP_ERASE, nfh_pkg::OP_QUEUE, nfh_pkg::OP_STAT_PLANE: addr_last = 2'h2;
         default: addr_last = 2'h0;
      endcase
   endfunction

   // Opening command byte per operation
   function automatic logic [7:0] first_cmd(input nfh_pkg::nfh_op_t op);
      unique case (op)
         nfh_pkg::OP_ERASE, nfh_pkg::OP_QUEUE: first_cmd = `NFH_CMD_ERASE_SETUP;
         nfh_pkg::OP_RESET: first_cmd = `NFH_CMD_RESET;
         nfh_pkg::OP_STAT: first_cmd = `NFH_CMD_STATUS;
         nfh_pkg::OP_STAT_PLANE: first_cmd = `NFH_CMD_STATUS_PLANE;
         nfh_pkg::OP_GET_FEAT: first_cmd = `NFH_CMD_GET_FEAT;
         default: first_cmd = `NFH_CMD_SET_FEAT;
      endcase
   endfunction

   assign strobe_end = (ph_q == 3'(`NFH_STROBE_CYC - 1));
   assign ctrl_wr = wr_in && (addr_in == `NFH_REG_CTRL);
   assign wop = nfh_pkg::nfh_op_t'(wdata_in[2:0]);
   assign busy = (st_q != nfh_pkg::S_IDLE);

   // ----------------------------------------------------------------
   // Acceptance of a new operation
   // ----------------------------------------------------------------
   always_comb begin
      op_ok = (wdata_in[2:0] != 3'h7);
      if (queued_q) begin
         // After a queue no feature operation may follow; erase or queue only on the other plane
         if (wop == nfh_pkg::OP_GET_FEAT || wop == nfh_pkg::OP_SET_FEAT) begin
            op_ok = 1'b0;
         end
         if ((wop == nfh_pkg::OP_ERASE || wop == nfh_pkg::OP_QUEUE) &&
             (row_q[`NFH_PLANE_BIT] == qplane_q)) begin
            op_ok = 1'b0;
         end
         if (wop == nfh_pkg::OP_QUEUE &&
             !(sr_q[`NFH_SR_READY] && sr_q[`NFH_SR_ARRAY_READY])) begin
            op_ok = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Sequencer, pins and software registers
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      op_d = op_q;
      ph_d = strobe_end ? 3'h0 : ph_q + 3'h1;
      idx_d = idx_q;
      wcnt_d = wcnt_q;
      seen_low_d = seen_low_q;
      row_d = row_q;
      data_d = data_q;
      sr_d = sr_q;
      queued_d = queued_q;
      qplane_d = qplane_q;
      refused_d = refused_q;
      rst_bad_d = rst_bad_q;
      wp_d = wp_n_out;
      rdata_d = 32'h0;
      pins_d = '{ce_n: 1'b0, cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_strobe_n: 1'b1,
                 io_oe_n: 1'b1, io_out: 8'h00};
      // Register writes other than the control word
      if (wr_in && addr_in == `NFH_REG_ADDR) begin
         row_d = wdata_in[23:0];
      end
      if (wr_in && addr_in == `NFH_REG_DATA && !busy) begin
         data_d = wdata_in;
      end
      if (wr_in && addr_in == `NFH_REG_WP) begin
         wp_d = wdata_in[0];
      end
      // Register reads
      if (rd_in) begin
         unique case (addr_in)
            `NFH_REG_ADDR: rdata_d = {8'h00, row_q};
            `NFH_REG_DATA: rdata_d = data_q;
            `NFH_REG_STAT: rdata_d = {16'h0000, sr_q, 4'h0, rst_bad_q, queued_q,
                                      refused_q, busy};
            `NFH_REG_WP: rdata_d = {31'h0, wp_n_out};
            default: rdata_d = 32'h0;
         endcase
      end
      // Pin drive per state and phase
      unique case (st_q)
         nfh_pkg::S_CMD1, nfh_pkg::S_CMD2, nfh_pkg::S_STCMD: begin
            pins_d.cle = 1'b1;
            pins_d.io_oe_n = 1'b0;
            pins_d.we_n = (ph_q >= 3'(`NFH_STROBE_LOW_CYC));
            if (st_q == nfh_pkg::S_CMD1) begin
               pins_d.io_out = first_cmd(op_q);
            end else if (st_q == nfh_pkg::S_STCMD) begin
               pins_d.io_out = `NFH_CMD_STATUS;
            end else begin
               pins_d.io_out = (op_q == nfh_pkg::OP_QUEUE) ? `NFH_CMD_QUEUE_CONF
                                                             : `NFH_CMD_ERASE_CONF;
            end
         end
         nfh_pkg::S_ADDR: begin
            pins_d.ale = 1'b1;
            pins_d.io_oe_n = 1'b0;
            pins_d.we_n = (ph_q >= 3'(`NFH_STROBE_LOW_CYC));
            pins_d.io_out = row_q[8*idx_q +: 8];
            if (idx_q == 2'h0 && op_q != nfh_pkg::OP_STAT_PLANE &&
                (op_q == nfh_pkg::OP_ERASE || op_q == nfh_pkg::OP_QUEUE)) begin
               pins_d.io_out[`NFH_PAGE_BITS-1:0] = '0;
            end
         end
         nfh_pkg::S_WDATA: begin
            pins_d.io_oe_n = 1'b0;
            pins_d.we_n = (ph_q >= 3'(`NFH_STROBE_LOW_CYC));
            pins_d.io_out = data_q[8*idx_q +: 8];
            if (row_q[7:0] == `NFH_FEAT_DRIVE || row_q[7:0] == `NFH_FEAT_PULLDOWN) begin
               pins_d.io_out = (idx_q == 2'h0) ? (data_q[7:0] & `NFH_STRENGTH_MASK)
                                               : 8'h00;
            end
         end
         nfh_pkg::S_RDATA: begin
            pins_d.read_strobe_n = strobe_end;
         end
         default: begin
            pins_d.ce_n = (st_q == nfh_pkg::S_IDLE);
         end
      endcase
      // Sequence stepping
      unique case (st_q)
         nfh_pkg::S_IDLE: begin
            ph_d = 3'h0;
            if (ctrl_wr) begin
               refused_d = !op_ok;
               if (op_ok) begin
                  op_d = wop;
                  idx_d = 2'h0;
                  st_d = nfh_pkg::S_CMD1;
               end
            end
         end
         nfh_pkg::S_CMD1: begin
            if (strobe_end) begin
               idx_d = 2'h0;
               unique case (op_q)
                  nfh_pkg::OP_RESET: st_d = nfh_pkg::S_WAIT;
                  nfh_pkg::OP_STAT: st_d = nfh_pkg::S_RDATA;
                  default: st_d = nfh_pkg::S_ADDR;
               endcase
               if (op_q == nfh_pkg::OP_RESET) begin
                  queued_d = 1'b0;
               end
            end
         end
         nfh_pkg::S_ADDR: begin
            if (strobe_end) begin
               idx_d = idx_q + 2'h1;
               if (idx_q == addr_last(op_q)) begin
                  idx_d = 2'h0;
                  unique case (op_q)
                     nfh_pkg::OP_STAT_PLANE: st_d = nfh_pkg::S_RDATA;
                     nfh_pkg::OP_GET_FEAT: st_d = nfh_pkg::S_WAIT;
                     nfh_pkg::OP_SET_FEAT: st_d = nfh_pkg::S_WDATA;
                     default: st_d = nfh_pkg::S_CMD2;
                  endcase
               end
            end
         end
         nfh_pkg::S_CMD2: begin
            if (strobe_end) begin
               st_d = nfh_pkg::S_WAIT;
               queued_d = (op_q == nfh_pkg::OP_QUEUE);
               qplane_d = row_q[`NFH_PLANE_BIT];
            end
         end
         nfh_pkg::S_WDATA: begin
            if (strobe_end) begin
               idx_d = idx_q + 2'h1;
               if (idx_q == 2'h3) begin
                  st_d = nfh_pkg::S_WAIT;
               end
            end
         end
         nfh_pkg::S_WAIT: begin
            // Busy window: a low must show within the busy-start time
            ph_d = 3'h0;
            wcnt_d = wcnt_q + 4'h1;
            if (!rb_s) begin
               seen_low_d = 1'b1;
            end
            if ((seen_low_q && rb_s) || (!seen_low_q && wcnt_q == 4'(`NFH_WB_CYC))) begin
               wcnt_d = 4'h0;
               seen_low_d = 1'b0;
               idx_d = 2'h0;
               unique case (op_q)
                  nfh_pkg::OP_GET_FEAT: st_d = nfh_pkg::S_RDATA;
                  nfh_pkg::OP_SET_FEAT: st_d = nfh_pkg::S_IDLE;
                  default: st_d = nfh_pkg::S_STCMD;
               endcase
            end
            if (ctrl_wr && wop == nfh_pkg::OP_RESET) begin
               op_d = nfh_pkg::OP_RESET;
               st_d = nfh_pkg::S_CMD1;
               wcnt_d = 4'h0;
               seen_low_d = 1'b0;
               refused_d = 1'b0;
            end
         end
         nfh_pkg::S_STCMD: begin
            if (strobe_end) begin
               st_d = nfh_pkg::S_RDATA;
            end
         end
         default: begin
            if (strobe_end) begin
               idx_d = idx_q + 2'h1;
               if (op_q == nfh_pkg::OP_GET_FEAT) begin
                  data_d[8*idx_q +: 8] = io_s;
               end else begin
                  sr_d = io_s;
               end
               if (op_q == nfh_pkg::OP_RESET) begin
                  rst_bad_d = io_s != (wp_n_out ? `NFH_SR_RST_WP_HI
                                                : `NFH_SR_RST_WP_LO);
               end
               if (op_q == nfh_pkg::OP_ERASE && io_s[`NFH_SR_READY]) begin
                  queued_d = 1'b0;
               end
               if (op_q != nfh_pkg::OP_GET_FEAT || idx_q == 2'h3) begin
                  st_d = nfh_pkg::S_IDLE;
               end
            end
         end
      endcase
      if (busy && ctrl_wr && !(st_q == nfh_pkg::S_WAIT && wop == nfh_pkg::OP_RESET)) begin
         refused_d = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_q <= nfh_pkg::S_IDLE;
         op_q <= nfh_pkg::OP_STAT;
         ph_q <= 3'h0;
         idx_q <= 2'h0;
         wcnt_q <= 4'h0;
         seen_low_q <= 1'b0;
         row_q <= 24'h000000;
         data_q <= 32'h00000000;
         sr_q <= 8'h00;
         queued_q <= 1'b0;
         qplane_q <= 1'b0;
         refused_q <= 1'b0;
         rst_bad_q <= 1'b0;
         wp_n_out <= `NFH_WP_RESET;
         rdata_out <= 32'h00000000;
         pins_out <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_strobe_n: 1'b1,
                       io_oe_n: 1'b1, io_out: 8'h00};
      end else begin
         st_q <= st_d;
         op_q <= op_d;
         ph_q <= ph_d;
         idx_q <= idx_d;
         wcnt_q <= wcnt_d;
         seen_low_q <= seen_low_d;
         row_q <= row_d;
         data_q <= data_d;
         sr_q <= sr_d;
         queued_q <= queued_d;
         qplane_q <= qplane_d;
         refused_q <= refused_d;
         rst_bad_q <= rst_bad_d;
         wp_n_out <= wp_d;
         rdata_out <= rdata_d;
         pins_out <= pins_d;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   chk_erase_setup_byte: assert property (
      st_q == nfh_pkg::S_CMD1 && op_q == nfh_pkg::OP_ERASE && ph_q == 3'h0 |=>
      pins_out.cle && pins_out.io_out == 8'h60 && !pins_out.io_oe_n)
      else $error("erase setup byte wrong");
   chk_confirm_byte: assert property (
      st_q == nfh_pkg::S_CMD2 && ph_q == 3'h2 |=>
      pins_out.io_out == ((op_q == nfh_pkg::OP_QUEUE) ? 8'hD1 : 8'hD0) && pins_out.cle)
      else $error("confirm byte wrong");
   chk_page_bits_zero: assert property (
      st_q == nfh_pkg::S_ADDR && idx_q == 2'h0 && op_q == nfh_pkg::OP_ERASE && ph_q == 3'h1
      |=> pins_out.ale && pins_out.io_out[5:0] == 6'h00)
      else $error("page bits not cleared");
   chk_reset_aborts: assert property (
      st_q == nfh_pkg::S_WAIT && ctrl_wr && wdata_in[2:0] == 3'h2 |=>
      st_q == nfh_pkg::S_CMD1 && op_q == nfh_pkg::OP_RESET ##8 pins_out.io_out == 8'hFF)
      else $error("reset did not abort busy wait");
   chk_wait_holds_busy: assert property (
      st_q == nfh_pkg::S_WAIT && seen_low_q && !rb_s && !ctrl_wr |=> st_q == nfh_pkg::S_WAIT)
      else $error("left busy wait while device busy");
   chk_four_feat_bytes: assert property (
      st_q == nfh_pkg::S_WDATA && $changed(st_q) |-> idx_q == 2'h0 ##31
      st_q == nfh_pkg::S_WDATA ##1 st_q == nfh_pkg::S_WAIT)
      else $error("feature write not four bytes");
   chk_strength_masked: assert property (
      st_q == nfh_pkg::S_WDATA && row_q[7:0] == 8'h80 && ph_q == 3'h3 |=>
      pins_out.io_out[7:2] == 6'h00)
      else $error("strength reserved bits not zero");
   chk_status_after_erase: assert property (
      st_q == nfh_pkg::S_STCMD && ph_q == 3'h0 |=> pins_out.io_out == 8'h70 ##7
      st_q == nfh_pkg::S_RDATA)
      else $error("status read not issued after busy");
   chk_plane_differs: assert property (
      st_q == nfh_pkg::S_CMD2 && queued_q && strobe_end |-> row_q[6] != qplane_q)
      else $error("queued planes equal");
   chk_read_released: assert property (
      st_q == nfh_pkg::S_RDATA && ph_q == 3'h1 |=> pins_out.io_oe_n && !pins_out.read_strobe_n)
      else $error("bus driven during read");

   cov_erase_done: cover property (st_q == nfh_pkg::S_STCMD && op_q == nfh_pkg::OP_ERASE);
   cov_queue_then_erase: cover property (queued_q && st_q == nfh_pkg::S_CMD2 &&
                                         op_q == nfh_pkg::OP_ERASE);
   cov_reset_abort: cover property (st_q == nfh_pkg::S_WAIT && ctrl_wr &&
                                    wdata_in[2:0] == 3'h2);
   cov_get_feature: cover property (st_q == nfh_pkg::S_RDATA && op_q == nfh_pkg::OP_GET_FEAT
                                    && idx_q == 2'h3 && strobe_end);

endmodule
`default_nettype wire

// >>> hw/nfh_pkg.sv
// Purpose: types of the NAND host sequencer
// Assumes: constants live in nfh_defs.svh
// Notes: operation codes follow the order of nfh_op_t
package nfh_pkg;

   // ----------------------------------------------------------------
   // Operations and sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_ERASE, OP_QUEUE, OP_RESET, OP_STAT, OP_STAT_PLANE, OP_GET_FEAT, OP_SET_FEAT
   } nfh_op_t;

   typedef enum logic [3:0] {
      S_IDLE, S_CMD1, S_ADDR, S_CMD2, S_WDATA, S_WAIT, S_STCMD, S_RDATA
   } nfh_state_t;

   // ----------------------------------------------------------------
   // Device-facing pin group
   // ----------------------------------------------------------------
   typedef struct packed {
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic read_strobe_n;
      logic io_oe_n;
      logic [7:0] io_out;
   } nfh_pins_t;

endpackage

// >>> hw/nfh_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk_in
// Notes: a bit changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module nfh_sync #(
   parameter int WIDTH = 9
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [WIDTH-1:0] d_in,
   output var logic [WIDTH-1:0] q_out
);

   // ----------------------------------------------------------------
   // Per-bit synchroniser
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic s1_q, s2_q, s3_q, o_q, o_d;
         // Filter: accept only an agreed value
         always_comb begin
            o_d = (s2_q == s3_q) ? s3_q : o_q;
         end
         // Stage registers
         always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
               s1_q <= 1'b1;
               s2_q <= 1'b1;
               s3_q <= 1'b1;
               o_q <= 1'b1;
            end else begin
               s1_q <= d_in[gi];
               s2_q <= s1_q;
               s3_q <= s2_q;
               o_q <= o_d;
            end
         end
         assign q_out[gi] = o_q;
      end
   endgenerate

endmodule
`default_nettype wire

// >>> verif/nand_erase_reset_feature_engine_bench.sv
// Purpose: self-checking bench of the NAND host sequencer
// Assumes: software port strobes, read data one cycle later
// Notes: device side is nfh_dev_model
`include "nfh_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module nand_erase_reset_feature_engine_bench;
   logic clk_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0;
   logic [7:0] addr_in = 0, dev_io;
   logic [31:0] wdata_in = 0, rdata_out, st;
   logic wp_n_out, rb_n;
   logic [23:0] row;
   nfh_pkg::nfh_pins_t pins;
   wire logic [7:0] io = pins.io_oe_n ? dev_io : pins.io_out;
   int miscompares = 0, compares = 0;
   nfh_host i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .io_in(io),
      .ready_busy_n_in(rb_n), .pins_out(pins), .wp_n_out(wp_n_out));
   nfh_dev_model i_dev (.pins_in(pins), .io_in(io), .wp_n_in(wp_n_out), .io_out(dev_io),
      .rb_n_out(rb_n), .row_out(row));
   always #5 clk_in = ~clk_in;
   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      {addr_in, rd_in} <= {a, 1'b1};
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask
   // Start an operation and poll until the sequencer is idle
   task automatic run(input logic [31:0] a, input logic [31:0] d, input logic [2:0] op);
      wr(`NFH_REG_ADDR, a);
      wr(`NFH_REG_DATA, d);
      wr(`NFH_REG_CTRL, {29'h0, op});
      for (int i = 0; i < 2000; i++) begin
         rd(`NFH_REG_STAT, st);
         if (st[0] === 1'b0) break;
      end
      // Poll limit run out counts as a mismatch
      if (st[0] !== 1'b0) miscompares++;
   endtask
   task automatic print_verdict();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (50000) @(posedge clk_in);
      miscompares++;
      print_verdict();
   end
   // Test sequence
   initial begin
      repeat (12) @(posedge clk_in);
      rstn_in <= 1'b1;
      rd(`NFH_REG_WP, st);
      chk(st[0], 1'b1);
      rd(8'h20, st);
      chk(st, 32'h0);
      run(0, 0, 3'h2);
      chk({st[15:8], st[3]}, 9'h1C0);
      wr(`NFH_REG_WP, 32'h0);
      run(0, 0, 3'h2);
      chk({st[15:8], wp_n_out}, 9'h0C0);
      wr(`NFH_REG_WP, 32'h1);
      foreach (st[i]) if (i < 2) begin
         run(32'h80 + i, 32'hFFFFFF02 - i, 3'h6);
         run(32'h80 + i, 0, 3'h5);
         rd(`NFH_REG_DATA, st);
         chk(st, 32'h2 - i);
      end
      run(0, 0, 3'h2);
      run(32'h80, 0, 3'h5);
      rd(`NFH_REG_DATA, st);
      chk(st, 32'h2);
      run(32'h10, 32'h12345678, 3'h6);
      run(32'h10, 0, 3'h5);
      rd(`NFH_REG_DATA, st);
      chk(st, 32'h0);
      run(32'h01237F, 0, 3'h0);
      chk({st[15:8], row}, 32'hE0012340);
      // Erase aborted by a reset during its busy wait
      wr(`NFH_REG_CTRL, 32'h0);
      repeat (48) @(posedge clk_in);
      run(0, 0, 3'h2);
      chk(st[15:0], 16'hE000);
      run(32'h000A80, 0, 3'h1);
      chk(st[2], 1'b1);
      wr(`NFH_REG_CTRL, 32'h1);
      rd(`NFH_REG_STAT, st);
      chk(st[1], 1'b1);
      run(32'h0155C0, 0, 3'h4);
      chk(st[15:8], 8'hE0);
      run(32'h0155C0, 0, 3'h0);
      chk({st[2], row}, 25'h0155C0);
      run(0, 0, 3'h3);
      chk(st[15:8], 8'hE0);
      wr(`NFH_REG_CTRL, 32'h7);
      rd(`NFH_REG_STAT, st);
      chk(st[1:0], 2'h2);
      print_verdict();
   end
endmodule
`default_nettype wire

// >>> verif/nfh_dev_model.sv
// Purpose: behavioural NAND target facing the host sequencer
// Assumes: host strobes arrive on the pins struct
// Notes: busy periods shortened to 300 ns
`timescale 1ns/1ps
`default_nettype none
module nfh_dev_model (
   input wire nfh_pkg::nfh_pins_t pins_in,
   input wire logic [7:0] io_in,
   input wire logic wp_n_in,
   output logic [7:0] io_out,
   output logic rb_n_out,
   output logic [23:0] row_out
);
   logic [7:0] cmd_q, fsel_q;
   logic [31:0] f80_q, f81_q, buf_q;
   int acnt, dcnt, busy_tok;
   bit feat_rd;
   // Busy period after a latched command; a newer command (reset) restarts it
   task automatic go_busy();
      int tok;
      busy_tok++;
      tok = busy_tok;
      #23 rb_n_out = 1'b0;
      #300 if (tok == busy_tok) rb_n_out = 1'b1;
   endtask
   // Power-on defaults
   initial begin
      {f80_q, f81_q} = '0;
      {rb_n_out, io_out, row_out, feat_rd, acnt, dcnt} = {1'b1, 8'hA5, 24'h0, 1'b0, 64'h0};
   end
   // Latch command, address and data on the rising write strobe
   always @(posedge pins_in.we_n) begin
      if (!pins_in.ce_n && pins_in.cle) begin
         {cmd_q, acnt, dcnt, feat_rd} = {io_in, 64'h0, 1'b0};
         if (io_in == 8'hD0 || io_in == 8'hD1 || io_in == 8'hFF) fork go_busy(); join_none
      end else if (!pins_in.ce_n && pins_in.ale) begin
         row_out[8*acnt+:8] = io_in;
         acnt++;
         fsel_q = io_in;
         buf_q = (io_in == 8'h80) ? f80_q : (io_in == 8'h81) ? f81_q : '0;
         feat_rd = (cmd_q == 8'hEE);
         if (feat_rd) fork go_busy(); join_none
      end else if (!pins_in.ce_n && cmd_q == 8'hEF) begin
         buf_q[8*dcnt+:8] = io_in;
         dcnt++;
         if (dcnt == 4 && fsel_q == 8'h80) f80_q = buf_q;
         if (dcnt == 4 && fsel_q == 8'h81) f81_q = buf_q;
         if (dcnt == 4) fork go_busy(); join_none
      end
   end
   // Byte out on falling read strobe, inverted once released
   always @(negedge pins_in.read_strobe_n) begin
      io_out = feat_rd ? buf_q[7:0] : {wp_n_in, rb_n_out, rb_n_out, 5'h00};
      if (feat_rd) buf_q = buf_q >> 8;
   end
   always @(posedge pins_in.read_strobe_n) io_out = ~io_out;
endmodule
`default_nettype wire
